// ===== design/fsb_cpu_end.sv
// Purpose: Processor end of the request-phase address link.
// Assumes: Core requests arrive on mclk; the link logic runs on the link clock.
// Notes:   Requests cross by a toggle handshake; the held words stay stable until ack.
`timescale 1ns/1ps
`default_nettype none
`include "fsb_params.svh"
// Contract
// - Mask address bit twenty before lookup and drive.
// - Masking gives one-megabyte wrap-around like predecessor.
// - Agent asserts mask only in real mode.
// - Mask valid by target-ready of I/O write.
// - Valid strobe marks address and type valid.
// - Agents start decode and checks on strobe.
// - Capture on both edges of source strobes.
// - Strobe zero carries type and address 16..3.
// - Sample address straps at power-on for configuration.
module fsb_cpu_end
    import fsb_pkg::*;
(
    // Core clock and reset
    input  wire logic  mclk,
    input  wire logic  rst_n,
    // Bus link
    fsb_link_if.cpu    link,
    // Core request port
    input  wire logic  req_valid,
    output logic       req_ready,
    input  wire word_s req_word_a,
    input  wire word_s req_word_b,
    // Core-side status
    output addr_t      lookup_addr,
    output logic       mask_active,
    output logic [`CFG_MSB:`CFG_LSB] power_on_cfg
);

    // Core-domain state.
    word_s      hold_a;
    word_s      hold_b;
    logic       req_tgl;
    logic       ack_s1;
    logic       ack_s2;
    logic       mask_s1;
    logic       mask_s2;
    logic [`CFG_MSB:`CFG_LSB] cfg_s1;

    // Link-domain state.
    logic       lrst_s1;
    logic       lrst_n;
    logic       req_s1;
    logic       req_s2;
    logic       req_s3;
    logic       lmask_s1;
    logic       lmask_s2;
    logic       ack_tgl;
    phase_e     state;
    addr_t      pin_addr;
    req_t       pin_req;
    logic       pin_valid;
    logic       drive;
    logic [1:0] pin_strobe;
    logic       strobe_oe;
    logic       cfg_taken;
    logic [`CFG_MSB:`CFG_LSB] cfg_cap;
    logic       start;

    // Clears bit twenty when the mask is active; used for lookup and for launch.
    function automatic addr_t bit20_clear(input addr_t a, input logic m);
        addr_t r;
        r = a;
        if (m) begin
            r[`ADDRESS_BIT_TWENTY] = 1'b0;
        end
        return r;
    endfunction

    // Accept a request only when the previous one has been acknowledged.
    assign req_ready = rst_n && (req_tgl == ack_s2);

    // Hold the request words and flip the request toggle.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            hold_a  <= '0;
            hold_b  <= '0;
            req_tgl <= 1'b0;
        end else if (req_valid && req_ready) begin
            hold_a  <= req_word_a;
            hold_b  <= req_word_b;
            req_tgl <= ~req_tgl;
        end
    end

    // Acknowledge toggle back into the core domain.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
        end else begin
            ack_s1 <= ack_tgl;
            ack_s2 <= ack_s1;
        end
    end

    // The mask pin is asynchronous, so it is synchronised before the lookup uses it.
    // Reset to the released level so mask_active is never unknown after reset.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mask_s1 <= 1'b1;
            mask_s2 <= 1'b1;
        end else begin
            mask_s1 <= link.addr_bit20_mask_in_n;
            mask_s2 <= mask_s1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mask_active <= 1'b0;
            lookup_addr <= '0;
        end else begin
            mask_active <= ~mask_s2;
            lookup_addr <= bit20_clear(req_word_a.addr, ~mask_s2);
        end
    end

    // configuration into core
    // The straps are static after reset, so a plain two-stage bus crossing is enough.
    always_ff @(posedge mclk) begin
        cfg_s1       <= cfg_cap;
        power_on_cfg <= cfg_s1;
    end

    // Link-side reset follows the core reset through two stages.
    always_ff @(posedge link.link_clk) begin
        lrst_s1 <= rst_n;
        lrst_n  <= lrst_s1;
    end

    // Request toggle and mask pin into the link domain.
    always_ff @(posedge link.link_clk) begin
        if (!lrst_n) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
        end else begin
            req_s1 <= req_tgl;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
        end
    end

    always_ff @(posedge link.link_clk) begin
        lmask_s1 <= link.addr_bit20_mask_in_n;
        lmask_s2 <= lmask_s1;
    end

    assign start = req_s2 ^ req_s3;

    // valid strobe launch
    // Two subphases; the valid strobe is low only during the first.
    always_ff @(posedge link.link_clk) begin
        if (!lrst_n) begin
            state     <= ph_idle;
            pin_addr  <= '1;
            pin_req   <= '1;
            pin_valid <= 1'b1;
            drive     <= 1'b0;
            ack_tgl   <= 1'b0;
        end else begin
            case (state)
                ph_idle: begin
                    if (start) begin
                        pin_addr  <= ~bit20_clear(hold_a.addr, ~lmask_s2);
                        pin_req   <= ~hold_a.kind;
                        pin_valid <= 1'b0;
                        drive     <= 1'b1;
                        state     <= ph_sub1;
                    end
                end
                ph_sub1: begin
                    pin_addr  <= ~hold_b.addr;
                    pin_req   <= ~hold_b.kind;
                    pin_valid <= 1'b1;
                    state     <= ph_sub2;
                end
                ph_sub2: begin
                    pin_addr <= '1;
                    pin_req  <= '1;
                    drive    <= 1'b0;
                    ack_tgl  <= ~ack_tgl;
                    state    <= ph_idle;
                end
                default: begin
                    state <= ph_idle;
                end
            endcase
        end
    end

    // source strobe pair
    // Strobes move on the falling clock edge so each edge sits mid-word.
    always_ff @(negedge link.link_clk) begin
        if (!lrst_n) begin
            pin_strobe <= 2'h3;
            strobe_oe  <= 1'b0;
        end else begin
            pin_strobe <= (state == ph_sub1) ? 2'h0 : 2'h3;
            strobe_oe  <= 1'b1;
        end
    end

    // strap sampling
    // Caught at the first link edge after reset release, before any drive starts.
    always_ff @(posedge link.link_clk) begin
        if (!lrst_n) begin
            cfg_taken <= 1'b0;
            cfg_cap   <= `CFG_RESET;
        end else if (!cfg_taken) begin
            cfg_taken <= 1'b1;
            cfg_cap   <= ~link.addr_n[`CFG_MSB:`CFG_LSB];
        end
    end

    // Pin drivers.
    assign link.cpu_addr_out   = pin_addr;
    assign link.cpu_addr_oe    = drive;
    assign link.cpu_req_out    = pin_req;
    assign link.cpu_req_oe     = drive;
    assign link.cpu_valid_out  = pin_valid;
    assign link.cpu_valid_oe   = drive;
    assign link.cpu_strobe_out = pin_strobe;
    assign link.cpu_strobe_oe  = strobe_oe;

endmodule // fsb_cpu_end
`default_nettype wire

// ===== design/fsb_params.svh
// Purpose: Shared constants for the request-phase address link.
// Assumes: Address lines run from bit 35 down to bit 3, active low on the wire.
// Notes:   Included by the package and by both link ends.
`ifndef FSB_PARAMS_SVH
`define FSB_PARAMS_SVH

// Address and request field positions.
`define ADDR_MSB            35
`define ADDR_LSB            3
`define REQ_MSB             4
`define ADDRESS_BIT_TWENTY  20
`define STROBE0_ADDR_MSB    16
`define STROBE1_ADDR_LSB    17

// Power-on configuration straps carried on a subset of the address lines.
`define CFG_MSB             7
`define CFG_LSB             3
`define CFG_RESET           5'h00

// Request type that the agent treats as an I/O write.
`define IO_WRITE_TYPE       5'h0A

// Address window claimed by the agent decoder, in units of address lines 35..3.
`define DECODE_BASE         33'h000000000
`define DECODE_LIMIT        33'h01FFFFFFF

`endif

// ===== design/fsb_pkg.sv
// Purpose: Types shared by both link ends and the link interface.
// Assumes: fsb_params.svh holds every numeric constant.
// Notes:   A request is two words, one per strobe edge.
`include "fsb_params.svh"
package fsb_pkg;

    typedef logic [`ADDR_MSB:`ADDR_LSB] addr_t;
    typedef logic [`REQ_MSB:0]          req_t;

    // One subphase of a request: address lines plus request-type lines.
    typedef struct packed {
        addr_t addr;
        req_t  kind;
    } word_s;

    // Request launcher phases on the link clock.
    typedef enum logic [1:0] {
        ph_idle,
        ph_sub1,
        ph_sub2
    } phase_e;

endpackage

// ===== design/fsb_link_if.sv
// Purpose: Wire-level meeting point of the processor end and the bus agent end.
// Assumes: All pins are active low with pull-ups; any driver pulling low wins.
// Notes:   Each driven pin except the agent's mask and ready pins is an output value plus an enable from its owner.
`timescale 1ns/1ps
`default_nettype none
interface fsb_link_if
    import fsb_pkg::*;
(
    input wire logic link_clk
);
    // Processor drives.
    addr_t      cpu_addr_out;
    logic       cpu_addr_oe;
    req_t       cpu_req_out;
    logic       cpu_req_oe;
    logic       cpu_valid_out;
    logic       cpu_valid_oe;
    logic [1:0] cpu_strobe_out;
    logic       cpu_strobe_oe;
    // Agent drives.
    addr_t      agent_addr_out;
    addr_t      agent_addr_oe;
    logic       addr_bit20_mask_in_n;
    logic       target_ready_signal_n;
    // Resolved wire levels.
    addr_t      addr_n;
    req_t       req_n;
    logic       request_address_valid_strobe_n;
    logic [1:0] address_source_strobes_n;

    // Open-drain resolution: an enabled low pulls the wire, otherwise it floats high.
    assign addr_n = ~({$bits(addr_t){cpu_addr_oe}} & ~cpu_addr_out)
                  & ~(agent_addr_oe & ~agent_addr_out);
    assign req_n  = ~({$bits(req_t){cpu_req_oe}} & ~cpu_req_out);
    assign request_address_valid_strobe_n = ~(cpu_valid_oe & ~cpu_valid_out);
    assign address_source_strobes_n = ~({2{cpu_strobe_oe}} & ~cpu_strobe_out);

    modport cpu (
        input  link_clk, addr_n, addr_bit20_mask_in_n,
        output cpu_addr_out, cpu_addr_oe, cpu_req_out, cpu_req_oe,
        output cpu_valid_out, cpu_valid_oe, cpu_strobe_out, cpu_strobe_oe
    );

    modport agent (
        input  link_clk, addr_n, req_n, request_address_valid_strobe_n,
        input  address_source_strobes_n,
        output agent_addr_out, agent_addr_oe, addr_bit20_mask_in_n, target_ready_signal_n
    );
endinterface
`default_nettype wire

// ===== design/fsb_agent_end.sv
// Purpose: Bus agent end: receives request phases, decodes, drives mask and ready.
// Assumes: The processor keeps the valid strobe low for exactly one link cycle.
// Notes:   Request words are latched on strobe edges, then taken on the link clock.
`timescale 1ns/1ps
`default_nettype none
`include "fsb_params.svh"
module fsb_agent_end
    import fsb_pkg::*;
(
    // Agent clock and reset
    input  wire logic  mclk,
    input  wire logic  rst_n,
    // Bus link
    fsb_link_if.agent  link,
    // Received requests
    output logic       rx_valid,
    output word_s      rx_word_a,
    output word_s      rx_word_b,
    output logic       rx_hit,
    output logic       proto_err,
    // Agent controls
    input  wire logic  mask_req,
    input  wire logic  io_done,
    input  wire logic [`CFG_MSB:`CFG_LSB] strap_value
);

    logic       address_source_strobe_low;
    logic       strobe_high;
    logic [`STROBE0_ADDR_MSB:`ADDR_LSB] lat_a_lo;
    logic [`STROBE0_ADDR_MSB:`ADDR_LSB] lat_b_lo;
    logic [`ADDR_MSB:`STROBE1_ADDR_LSB] lat_a_hi;
    logic [`ADDR_MSB:`STROBE1_ADDR_LSB] lat_b_hi;
    req_t       lat_a_kind;
    req_t       lat_b_kind;
    word_s      word_a;
    word_s      word_b;
    logic       lrst_s1;
    logic       lrst_n;
    logic       seen;
    logic       io_wait;
    logic       err_l;
    logic       rx_tgl;
    logic       cap_hit;
    word_s      cap_a;
    word_s      cap_b;
    logic       ready_pin;
    logic       mask_pin;
    logic       ms1;
    logic       ms2;
    logic       done_tgl;
    logic       ds1;
    logic       ds2;
    logic       ds3;
    logic [`CFG_MSB:`CFG_LSB] ss1;
    logic [`CFG_MSB:`CFG_LSB] ss2;
    addr_t      strap_out;
    addr_t      strap_oe;
    logic       rs1;
    logic       rs2;
    logic       rs3;
    logic       es1;

    // Address decoder for the claimed window.
    function automatic logic dec_hit(input addr_t a);
        return (a >= `DECODE_BASE) && (a <= `DECODE_LIMIT);
    endfunction

    assign address_source_strobe_low = link.address_source_strobes_n[0];
    assign strobe_high               = link.address_source_strobes_n[1];

    always_ff @(negedge address_source_strobe_low) begin
        lat_a_kind <= ~link.req_n;
        lat_a_lo   <= ~link.addr_n[`STROBE0_ADDR_MSB:`ADDR_LSB];
    end

    always_ff @(posedge address_source_strobe_low) begin
        lat_b_kind <= ~link.req_n;
        lat_b_lo   <= ~link.addr_n[`STROBE0_ADDR_MSB:`ADDR_LSB];
    end

    always_ff @(negedge strobe_high) begin
        lat_a_hi <= ~link.addr_n[`ADDR_MSB:`STROBE1_ADDR_LSB];
    end

    always_ff @(posedge strobe_high) begin
        lat_b_hi <= ~link.addr_n[`ADDR_MSB:`STROBE1_ADDR_LSB];
    end

    assign word_a = '{addr: {lat_a_hi, lat_a_lo}, kind: lat_a_kind};
    assign word_b = '{addr: {lat_b_hi, lat_b_lo}, kind: lat_b_kind};

    // Link reset and core-domain inputs pass two stages each.
    always_ff @(posedge link.link_clk) begin
        lrst_s1 <= rst_n;
        lrst_n  <= lrst_s1;
        ms1     <= mask_req;
        ms2     <= ms1;
        ss1     <= strap_value;
        ss2     <= ss1;
    end

    always_ff @(posedge link.link_clk) begin
        if (!lrst_n) begin
            ds1 <= 1'b0;
            ds2 <= 1'b0;
            ds3 <= 1'b0;
        end else begin
            ds1 <= done_tgl;
            ds2 <= ds1;
            ds3 <= ds2;
        end
    end

    // decode on valid strobe
    // The second word is latched mid-cycle after the strobe, so it is taken one cycle later.
    always_ff @(posedge link.link_clk) begin
        if (!lrst_n) begin
            seen      <= 1'b0;
            io_wait   <= 1'b0;
            err_l     <= 1'b0;
            rx_tgl    <= 1'b0;
            cap_hit   <= 1'b0;
            cap_a     <= '0;
            cap_b     <= '0;
            ready_pin <= 1'b1;
        end else begin
            seen      <= ~link.request_address_valid_strobe_n;
            ready_pin <= 1'b1;
            // A strobe longer than one cycle or during a pending I/O write is an error.
            if (!link.request_address_valid_strobe_n && (seen || io_wait)) begin
                err_l <= 1'b1;
            end
            if (seen) begin
                cap_a   <= word_a;
                cap_b   <= word_b;
                cap_hit <= dec_hit(word_a.addr);
                rx_tgl  <= ~rx_tgl;
                if (word_a.kind == `IO_WRITE_TYPE) begin
                    io_wait <= 1'b1;
                end else begin
                    ready_pin <= 1'b0;
                end
            end else if (io_wait && (ds2 ^ ds3)) begin
                io_wait   <= 1'b0;
                ready_pin <= 1'b0;
            end
        end
    end

    // mask level from agent
    // The mask level and the done toggle share equal two-stage paths.
    always_ff @(posedge link.link_clk) begin
        if (!lrst_n) begin
            mask_pin <= 1'b1;
        end else begin
            mask_pin <= ~ms2;
        end
    end

    always_ff @(posedge link.link_clk) begin
        strap_oe  <= '0;
        strap_out <= '1;
        if (!lrst_n) begin
            strap_oe[`CFG_MSB:`CFG_LSB]  <= '1;
            strap_out[`CFG_MSB:`CFG_LSB] <= ~ss2;
        end
    end

    assign link.agent_addr_out        = strap_out;
    assign link.agent_addr_oe         = strap_oe;
    assign link.addr_bit20_mask_in_n  = mask_pin;
    assign link.target_ready_signal_n = ready_pin;

    // I/O write completion from the agent core, sent as a toggle.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            done_tgl <= 1'b0;
        end else if (io_done) begin
            done_tgl <= ~done_tgl;
        end
    end

    // Received request into the core domain; captured words stay stable between requests.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rs1       <= 1'b0;
            rs2       <= 1'b0;
            rs3       <= 1'b0;
            es1       <= 1'b0;
            proto_err <= 1'b0;
            rx_valid  <= 1'b0;
            rx_hit    <= 1'b0;
            rx_word_a <= '0;
            rx_word_b <= '0;
        end else begin
            rs1       <= rx_tgl;
            rs2       <= rs1;
            rs3       <= rs2;
            es1       <= err_l;
            proto_err <= es1;
            rx_valid  <= rs2 ^ rs3;
            if (rs2 ^ rs3) begin
                rx_word_a <= cap_a;
                rx_word_b <= cap_b;
                rx_hit    <= cap_hit;
            end
        end
    end

endmodule // fsb_agent_end
`default_nettype wire

// ===== test/fsb_request_address_phase_chk.sv
// Purpose: Wire-level checks on the link between the processor end and the agent end.
// Assumes: Every pin is active low; the resolved wires come from the link interface.
// Notes:   Sampled on the link clock; a request is seen one tick after its valid strobe falls.
`timescale 1ns/1ps
`default_nettype none
`include "fsb_params.svh"
module fsb_request_address_phase_chk
    import fsb_pkg::*;
(
    // Link clock and core reset
    input wire logic       link_clk,
    input wire logic       rst_n,
    // Resolved wires
    input wire addr_t      addr_n,
    input wire req_t       req_n,
    input wire logic       request_address_valid_strobe_n,
    input wire logic [1:0] address_source_strobes_n,
    input wire logic       addr_bit20_mask_in_n,
    input wire logic       target_ready_signal_n,
    // Driver enables
    input wire logic       cpu_addr_oe,
    input wire logic       cpu_req_oe,
    input wire addr_t      agent_addr_oe
);
    default clocking cb @(posedge link_clk); endclocking
    default disable iff (!rst_n);

    logic [2:0] mask_low_cnt;

    // Counts how long the mask pin has been low, so that only a settled mask is judged.
    always_ff @(posedge link_clk) begin
        if (!rst_n || addr_bit20_mask_in_n) begin
            mask_low_cnt <= 3'h0;
        end else if (mask_low_cnt != 3'h7) begin
            mask_low_cnt <= mask_low_cnt + 3'h1;
        end
    end

    a_valid_single_cycle: assert property (
        $fell(request_address_valid_strobe_n) |=> request_address_valid_strobe_n)
        else $error("valid strobe held low longer than one link cycle");
    a_strobe_both_edges: assert property (
        $fell(request_address_valid_strobe_n) |->
            (address_source_strobes_n == 2'b00) ##1 (address_source_strobes_n == 2'b11))
        else $error("source strobes did not fall then rise around the request");
    a_strobe_pair_match: assert property (
        address_source_strobes_n[0] == address_source_strobes_n[1])
        else $error("the two source strobes differ");
    a_drive_span_exact: assert property (
        $fell(request_address_valid_strobe_n) |-> (cpu_addr_oe && cpu_req_oe)
            ##1 (cpu_addr_oe && cpu_req_oe) ##1 (!cpu_addr_oe && !cpu_req_oe))
        else $error("address and type lines not driven for exactly two subphases");
    a_mask_clears_bit: assert property (
        $fell(request_address_valid_strobe_n) && (mask_low_cnt >= 3'h5)
            |-> addr_n[`ADDRESS_BIT_TWENTY] == 1'b1)
        else $error("address bit twenty driven while mask asserted");
    a_ready_one_cycle: assert property (
        $fell(target_ready_signal_n) |=> $rose(target_ready_signal_n))
        else $error("target ready not a single link cycle pulse");
    a_ready_after_req: assert property (
        $fell(request_address_valid_strobe_n) && (req_n != ~`IO_WRITE_TYPE)
            |-> ##[1:3] !target_ready_signal_n)
        else $error("agent did not answer a request with target ready");
    a_strap_bits_only: assert property (
        (agent_addr_oe & ~33'h00000001F) == 33'h000000000)
        else $error("agent drives address lines outside the strap field");

    cover property ($fell(request_address_valid_strobe_n));
    cover property ($fell(target_ready_signal_n));
    cover property ($fell(request_address_valid_strobe_n) && (mask_low_cnt >= 3'h5));
endmodule // fsb_request_address_phase_chk
`default_nettype wire

// ===== test/fsb_request_address_phase_tb.sv
// Purpose: Self-checking bench joining the processor end and the agent end.
// Assumes: Both ends share one reset; the link clock is unrelated in phase to mclk.
// Notes:   Inputs change on the falling edge of mclk; every wait is bounded.
`timescale 1ns/1ps
`default_nettype none
`include "fsb_params.svh"
`define CHECK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin fails++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module fsb_request_address_phase_tb
    import fsb_pkg::*;
;
    logic                    mclk;
    logic                    link_clk;
    logic                    rst_n;
    logic                    req_valid;
    logic                    req_ready;
    word_s                   req_word_a;
    word_s                   req_word_b;
    addr_t                   lookup_addr;
    logic                    mask_active;
    logic [`CFG_MSB:`CFG_LSB] power_on_cfg;
    logic                    rx_valid;
    word_s                   rx_word_a;
    word_s                   rx_word_b;
    logic                    rx_hit;
    logic                    proto_err;
    logic                    mask_req;
    logic                    io_done;
    logic [`CFG_MSB:`CFG_LSB] strap_value;
    int                      fails;
    int                      num_checks;

    fsb_link_if link_if (.link_clk(link_clk));

    fsb_cpu_end fsb_cpu_end_inst (.mclk(mclk), .rst_n(rst_n), .link(link_if),
        .req_valid(req_valid), .req_ready(req_ready), .req_word_a(req_word_a),
        .req_word_b(req_word_b), .lookup_addr(lookup_addr), .mask_active(mask_active),
        .power_on_cfg(power_on_cfg));

    fsb_agent_end fsb_agent_end_inst (.mclk(mclk), .rst_n(rst_n), .link(link_if),
        .rx_valid(rx_valid), .rx_word_a(rx_word_a), .rx_word_b(rx_word_b), .rx_hit(rx_hit),
        .proto_err(proto_err), .mask_req(mask_req), .io_done(io_done),
        .strap_value(strap_value));

    fsb_request_address_phase_chk fsb_request_address_phase_chk_inst (
        .link_clk(link_clk), .rst_n(rst_n), .addr_n(link_if.addr_n), .req_n(link_if.req_n),
        .request_address_valid_strobe_n(link_if.request_address_valid_strobe_n),
        .address_source_strobes_n(link_if.address_source_strobes_n),
        .addr_bit20_mask_in_n(link_if.addr_bit20_mask_in_n),
        .target_ready_signal_n(link_if.target_ready_signal_n),
        .cpu_addr_oe(link_if.cpu_addr_oe), .cpu_req_oe(link_if.cpu_req_oe),
        .agent_addr_oe(link_if.agent_addr_oe));

    // Two free-running clocks with an odd offset; their edges still line up now and then, first at 375 ns.
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #16 link_clk = ~link_clk;
    end

    // Prints the verdict; the only place where the run ends.
    task automatic end_of_test;
        if (fails == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Hands one request to the processor end once it is ready, held for one taking edge.
    task automatic send_req(input word_s a, input word_s b);
        int n;
        n = 0;
        @(negedge mclk);
        while (req_ready !== 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        req_word_a = a;
        req_word_b = b;
        req_valid = 1'b1;
        @(negedge mclk);
        req_valid = 1'b0;
        `CHECK("ready after take", 1'b0, req_ready)
    endtask

    // Full transfer: wire words at both strobe edges, then the agent's received words.
    task automatic xfer(input word_s a, input word_s b, input addr_t a_exp, input logic hit);
        word_s w1;
        word_s w2;
        int    n;
        w1 = '0;
        w2 = '0;
        n = 0;
        send_req(a, b);
        fork
            begin
                @(negedge link_if.address_source_strobes_n[0]);
                w1 = {~link_if.addr_n, ~link_if.req_n};
                @(posedge link_if.address_source_strobes_n[0]);
                w2 = {~link_if.addr_n, ~link_if.req_n};
            end
            repeat (100) @(posedge mclk);
        join_any
        disable fork;
        `CHECK("wire subphase one", {a_exp, a.kind}, w1)
        `CHECK("wire subphase two", b, w2)
        while (rx_valid !== 1'b1 && n < 100) begin
            @(negedge mclk);
            n++;
        end
        `CHECK("rx valid", 1'b1, rx_valid)
        `CHECK("rx word a", {a_exp, a.kind}, rx_word_a)
        `CHECK("rx word b", b, rx_word_b)
        `CHECK("rx hit", hit, rx_hit)
        `CHECK("lookup address", a_exp, lookup_addr)
    endtask

    // Straps set before reset must show as the power-on configuration.
    task automatic test_straps;
        `CHECK("power on cfg", 5'h15, power_on_cfg)
        `CHECK("proto err after reset", 1'b0, proto_err)
    endtask

    // Back-to-back plain requests; bit twenty passes when no mask is asserted.
    task automatic test_plain;
        xfer('{33'h0AA123457, 5'h01}, '{33'h155EDCBA8, 5'h1F}, 33'h0AA123457, 1'b0);
        xfer('{33'h01FFFFFFF, 5'h1F}, '{33'h000000001, 5'h00}, 33'h01FFFFFFF, 1'b1);
    endtask

    // I/O write sets the mask before its ready; masked request wraps at one megabyte.
    task automatic test_io_mask;
        int n;
        n = 0;
        xfer('{33'h123456780, `IO_WRITE_TYPE}, '{33'h000000010, 5'h03}, 33'h123456780, 1'b0);
        `CHECK("ready held before io done", 1'b1, link_if.target_ready_signal_n)
        mask_req = 1'b1;
        io_done = 1'b1;
        @(negedge mclk);
        io_done = 1'b0;
        while (link_if.target_ready_signal_n !== 1'b0 && n < 30) begin
            @(negedge link_clk);
            n++;
        end
        `CHECK("io write ready", 1'b0, link_if.target_ready_signal_n)
        repeat (8) @(negedge mclk);
        `CHECK("mask active", 1'b1, mask_active)
        xfer('{33'h020002, 5'h02}, '{33'h020002, 5'h04}, 33'h000002, 1'b1);
        mask_req = 1'b0;
        repeat (12) @(negedge mclk);
        `CHECK("mask released", 1'b0, mask_active)
        xfer('{33'h020002, 5'h02}, '{33'h000003, 5'h05}, 33'h020002, 1'b1);
        `CHECK("no protocol error", 1'b0, proto_err)
    endtask

    // A request while an I/O write awaits completion is flagged; a mid-run reset clears it.
    task automatic test_refused;
        xfer('{33'h000000100, `IO_WRITE_TYPE}, '{33'h000000004, 5'h06}, 33'h000000100, 1'b1);
        xfer('{33'h000000200, 5'h01}, '{33'h000000008, 5'h07}, 33'h000000200, 1'b1);
        `CHECK("proto err on refused", 1'b1, proto_err)
        rst_n = 1'b0;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        repeat (8) @(negedge mclk);
        `CHECK("proto err cleared", 1'b0, proto_err)
        `CHECK("power on cfg again", 5'h15, power_on_cfg)
    endtask

    // Cuts a hang short well past the few microseconds the tests need.
    initial begin
        #200000;
        fails++;
        end_of_test();
    end

    // Reset both ends together, then run each scenario in turn.
    initial begin
        fails = 0;
        num_checks = 0;
        rst_n = 1'b0;
        req_valid = 1'b0;
        req_word_a = '0;
        req_word_b = '0;
        mask_req = 1'b0;
        io_done = 1'b0;
        strap_value = 5'h15;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        repeat (8) @(negedge mclk);
        test_straps();
        test_plain();
        test_io_mask();
        test_refused();
        end_of_test();
    end
endmodule // fsb_request_address_phase_tb
`default_nettype wire
